// ### atxcc_defs.svh
// Register offsets, field positions and reset values of the transmit context.
`ifndef ATXCC_DEFS_SVH
`define ATXCC_DEFS_SVH
`define ATXCC_CTRL_SET_OFS   12'h180
`define ATXCC_CTRL_CLR_OFS   12'h184
`define ATXCC_DESC_PTR_OFS   12'h18C
`define ATXCC_RUN_BIT        15
`define ATXCC_WAKE_BIT       12
`define ATXCC_DEAD_BIT       11
`define ATXCC_ACTIVE_BIT     10
`define ATXCC_EVT_MSB        4
`define ATXCC_CTRL_RW_MASK   32'h0000_9000
`define ATXCC_RUN_RESET      1'b0
`define ATXCC_DEAD_RESET     1'b0
`define ATXCC_ACTIVE_RESET   1'b0
`define ATXCC_WAKE_RESET     1'b0
`define ATXCC_EVT_RESET      5'h00
`define ATXCC_PTR_RESET      32'h0000_0000
`define ATXCC_EVT_UNKNOWN    5'h0E
`endif

// ### atxcc_pkg.sv
// Types shared by the transmit context control block.
package atxcc_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } atxcc_bus_req_s;

   typedef struct packed {
      logic        fetch_done;
      logic        fatal;
      logic        last_done;
      logic [4:0]  code;
   } atxcc_engine_evt_s;

   typedef enum logic [1:0] {
      ATXCC_IDLE,
      ATXCC_FETCH,
      ATXCC_WAIT
   } atxcc_state_e;
endpackage

// ### atxcc_ctrl.sv
// Control and descriptor pointer registers of the async request transmit DMA.
//
// Function
// - Writing ones at the set address sets those control bits.
// - Writing ones at the clear address clears those control bits.
// - Each access either sets or clears bits, never both at once.
// - Reads of set and clear addresses return the same control value.
// - Run enables descriptor processing; clearing run stops it.
// - Hardware clears run only on hardware or software reset; resets zero.
// - Setting wake continues or resumes descriptor processing.
// - Wake is cleared on every descriptor fetch, except when wake is set in that same cycle.
// - Dead sets on fatal error; read-only; resets to zero.
// - Dead clears when software clears run.
// - Active is one while processing descriptors, else zero; read-only.
// - Completion field loads ack or event code after each last command.
// - Pointer upper field holds 28 bits of a 16-byte aligned block.
// - Pointer low field gives the block count of the first block.
// - A zero block count marks the address invalid; no fetch happens.
// - Setting run fetches the first block from the pointer register.
`timescale 1ns/1ps
`default_nettype none
`include "atxcc_defs.svh"
module atxcc_ctrl
   import atxcc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              soft_reset,
   input  wire atxcc_bus_req_s    bus_req,
   output logic [31:0]            bus_rdata,
   output logic                   bus_rvalid,
   input  wire atxcc_engine_evt_s engine_evt,
   output logic                   fetch_req,
   output logic [27:0]            fetch_block_base,
   output logic [3:0]             fetch_block_count,
   output logic                   run_out
);

   // ********************************************************************
   // Address decode
   // ********************************************************************
   // One-hot select: bit 0 set, bit 1 clear, bit 2 pointer.
   // Unmapped offsets select nothing, so they read zero and ignore writes.
   function automatic logic [2:0] reg_select(input logic [11:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      if (addr == `ATXCC_CTRL_SET_OFS) begin
         sel = 3'h1;
      end else if (addr == `ATXCC_CTRL_CLR_OFS) begin
         sel = 3'h2;
      end else if (addr == `ATXCC_DESC_PTR_OFS) begin
         sel = 3'h4;
      end
      return sel;
   endfunction

   wire logic [2:0] reg_sel = reg_select(bus_req.addr);
   wire logic hit_set = reg_sel[0];
   wire logic hit_clr = reg_sel[1];
   wire logic hit_ptr = reg_sel[2];
   wire logic wr_set  = bus_req.wr && hit_set;
   wire logic wr_clr  = bus_req.wr && hit_clr && !hit_set;
   wire logic wr_ptr  = bus_req.wr && hit_ptr;

   // ********************************************************************
   // Control state
   // ********************************************************************
   logic         run_reg;
   logic         wake_reg;
   logic         dead_reg;
   logic         active_reg;
   logic [4:0]   evt_reg;
   logic [31:0]  ptr_reg;
   logic         fetch_req_reg;
   logic [31:0]  rdata_reg;
   logic         rvalid_reg;
   atxcc_state_e state_reg;
   atxcc_state_e state_next;

   // ********************************************************************
   // Write masking
   // ********************************************************************
   // Only run and wake may be written; status and reserved bits drop out,
   // so software cannot fake a dead or active state.
   function automatic logic [31:0] writable(input logic [31:0] value);
      return value & `ATXCC_CTRL_RW_MASK;
   endfunction

   wire logic [31:0] set_bits = writable(bus_req.wdata);
   wire logic [31:0] clr_bits = writable(bus_req.wdata);

   wire logic run_set  = wr_set && set_bits[`ATXCC_RUN_BIT];
   wire logic run_clr  = wr_clr && clr_bits[`ATXCC_RUN_BIT];
   wire logic wake_set = wr_set && set_bits[`ATXCC_WAKE_BIT];
   wire logic wake_clr = wr_clr && clr_bits[`ATXCC_WAKE_BIT];

   wire logic run_next  = run_set ? 1'b1 : (run_clr ? 1'b0 : run_reg);
   wire logic ptr_valid = ptr_reg[3:0] != 4'h0;
   wire logic fetch_now = state_reg == ATXCC_FETCH && ptr_valid;
   // A wake request in the fetch cycle wins over the hardware clear.
   wire logic wake_next = wake_set ? 1'b1 :
      ((wake_clr || engine_evt.fetch_done || fetch_now) ? 1'b0 :
       wake_reg);
   // A fatal error raised as run is cleared keeps dead set.
   wire logic dead_next = (engine_evt.fatal && run_reg) ? 1'b1 :
      (run_clr ? 1'b0 : dead_reg);

   wire logic stop_now    = !run_next || dead_next;
   wire logic first_start = run_set && !run_reg;
   wire logic wake_resume = run_reg && wake_set && !dead_reg;

   // ********************************************************************
   // Processing sequence
   // ********************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ATXCC_IDLE: begin
            if (first_start) begin
               state_next = ATXCC_FETCH;
            end
         end
         ATXCC_FETCH: begin
            if (stop_now) begin
               state_next = ATXCC_IDLE;
            end else if (ptr_valid) begin
               state_next = ATXCC_WAIT;
            end else begin
               state_next = ATXCC_IDLE;
            end
         end
         ATXCC_WAIT: begin
            if (stop_now) begin
               state_next = ATXCC_IDLE;
            end else if (engine_evt.last_done && !ptr_valid) begin
               state_next = ATXCC_IDLE;
            end
         end
         default: begin
            state_next = ATXCC_IDLE;
         end
      endcase
      // A wake while idle with run set and dead clear resumes processing.
      if (state_reg == ATXCC_IDLE && wake_resume) begin
         state_next = ATXCC_FETCH;
      end
   end

   wire logic active_next = state_next != ATXCC_IDLE;

   // ********************************************************************
   // Registers
   // ********************************************************************
   // Soft reset stops the context but keeps the pointer and event code,
   // so software can still read why the last packet ended.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         run_reg <= `ATXCC_RUN_RESET;
      end else if (soft_reset) begin
         run_reg <= `ATXCC_RUN_RESET;
      end else begin
         run_reg <= run_next;
      end
   end

   // Wake has no defined reset value; zero avoids a spurious resume.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wake_reg <= `ATXCC_WAKE_RESET;
      end else if (soft_reset) begin
         wake_reg <= `ATXCC_WAKE_RESET;
      end else begin
         wake_reg <= wake_next;
      end
   end

   // ********************************************************************
   // Status flags
   // ********************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dead_reg <= `ATXCC_DEAD_RESET;
      end else if (soft_reset) begin
         dead_reg <= `ATXCC_DEAD_RESET;
      end else begin
         dead_reg <= dead_next;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         active_reg <= `ATXCC_ACTIVE_RESET;
      end else if (soft_reset) begin
         active_reg <= `ATXCC_ACTIVE_RESET;
      end else begin
         active_reg <= active_next;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ATXCC_IDLE;
      end else if (soft_reset) begin
         state_reg <= ATXCC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ********************************************************************
   // Pointer and event code
   // ********************************************************************

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         evt_reg <= `ATXCC_EVT_RESET;
      end else if (engine_evt.last_done) begin
         evt_reg <= engine_evt.code;
      end
   end

   // The pointer is not guarded; software keeps it still while running.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ptr_reg <= `ATXCC_PTR_RESET;
      end else if (wr_ptr) begin
         ptr_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fetch_req_reg <= 1'b0;
      end else begin
         fetch_req_reg <= fetch_now && run_next && !dead_next;
      end
   end

   // ********************************************************************
   // Read path
   // ********************************************************************
   // Packs the status word; reserved positions stay zero.
   function automatic logic [31:0] ctrl_pack(input logic       run,
                                            input logic       wake,
                                            input logic       dead,
                                            input logic       active,
                                            input logic [4:0] code);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[`ATXCC_RUN_BIT]    = run;
      word[`ATXCC_WAKE_BIT]   = wake;
      word[`ATXCC_DEAD_BIT]   = dead;
      word[`ATXCC_ACTIVE_BIT] = active;
      word[`ATXCC_EVT_MSB:0]  = code;
      return word;
   endfunction

   wire logic [31:0] ctrl_view = ctrl_pack(run_reg, wake_reg, dead_reg,
                                           active_reg, evt_reg);
   wire logic [31:0] rd_mux = (hit_set || hit_clr) ? ctrl_view :
                              (hit_ptr ? ptr_reg : 32'h0000_0000);

   // Read data holds until the next read, so a slow master may take it late.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_req.rd) begin
         rdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= bus_req.rd;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign bus_rdata         = rdata_reg;
   assign bus_rvalid        = rvalid_reg;
   assign fetch_req         = fetch_req_reg;
   assign fetch_block_base  = ptr_reg[31:4];
   assign fetch_block_count = ptr_reg[3:0];
   assign run_out           = run_reg;

endmodule
`default_nettype wire

// ### atxcc_ctrl_properties.sv
// Port-level assertions of the transmit context control block.
`timescale 1ns/1ps
`default_nettype none
module atxcc_ctrl_properties
   import atxcc_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire logic              soft_reset,
   input wire atxcc_bus_req_s    bus_req,
   input wire logic [31:0]       bus_rdata,
   input wire logic              bus_rvalid,
   input wire atxcc_engine_evt_s engine_evt,
   input wire logic              fetch_req,
   input wire logic [27:0]       fetch_block_base,
   input wire logic [3:0]        fetch_block_count,
   input wire logic              run_out
);
   wire logic set_run;
   wire logic clr_run;
   assign set_run = bus_req.wr && bus_req.addr == 12'h180 && bus_req.wdata[15];
   assign clr_run = bus_req.wr && bus_req.addr == 12'h184 && bus_req.wdata[15];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   chk_read_answered: assert property (bus_req.rd |=> bus_rvalid)
      else $error("read not answered");
   chk_rvalid_cause: assert property (bus_rvalid |-> $past(bus_req.rd))
      else $error("stray read valid");
   chk_run_set: assert property (set_run && !soft_reset |=> run_out)
      else $error("run not set");
   chk_run_clear: assert property (clr_run |=> !run_out)
      else $error("run not cleared");
   chk_run_kept: assert property ($fell(run_out) |-> $past(clr_run || soft_reset))
      else $error("run dropped by itself");
   chk_fetch_run: assert property (fetch_req |-> run_out)
      else $error("fetch without run");
   chk_fetch_count: assert property (fetch_req |-> fetch_block_count != 4'h0)
      else $error("fetch with zero count");
   chk_first_fetch: assert property (set_run && !run_out && !soft_reset
      && fetch_block_count != 4'h0 |-> ##2 fetch_req)
      else $error("first fetch missing");
   chk_ptr_load: assert property (bus_req.wr && bus_req.addr == 12'h18C
      |=> {fetch_block_base, fetch_block_count} == $past(bus_req.wdata))
      else $error("pointer not loaded");
   chk_rsvd_zero: assert property (bus_rvalid && $past(bus_req.addr) inside
      {12'h180, 12'h184} |-> (bus_rdata & 32'hFFFF_63E0) == 32'h0)
      else $error("reserved bits not zero");
   cover property (fetch_req);
   cover property ($fell(run_out));
   cover property (bus_rvalid && bus_rdata[11]);
endmodule
bind atxcc_ctrl atxcc_ctrl_properties i_props (.sys_clk(sys_clk), .reset(reset),
   .soft_reset(soft_reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .bus_rvalid(bus_rvalid), .engine_evt(engine_evt), .fetch_req(fetch_req),
   .fetch_block_base(fetch_block_base), .fetch_block_count(fetch_block_count),
   .run_out(run_out));
`default_nettype wire

// ### atxcc_ctrl_tb.sv
// Self-checking bench of the transmit context control block.
`timescale 1ns/1ps
`default_nettype none
module atxcc_ctrl_tb
   import atxcc_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              reset = 1'b1;
   logic              soft_reset = 1'b0;
   atxcc_bus_req_s    bus_req = '0;
   atxcc_engine_evt_s engine_evt = '0;
   logic [31:0]       bus_rdata, ptr, rd_val;
   logic              bus_rvalid, fetch_req, run_out;
   logic [27:0]       fetch_block_base;
   logic [3:0]        fetch_block_count;
   logic [4:0]        code;
   int                num_errors = 0, checks = 0, fetches = 0, cyc = 0, n;
   atxcc_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .soft_reset(soft_reset),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
      .engine_evt(engine_evt), .fetch_req(fetch_req),
      .fetch_block_base(fetch_block_base),
      .fetch_block_count(fetch_block_count), .run_out(run_out));
   always #5 sys_clk = ~sys_clk;
   task automatic end_of_test();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // The ceiling is over thirty times the length of the sequence below.
   always @(posedge sys_clk) begin
      if (fetch_req === 1'b1) fetches <= fetches + 1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] ctrl_exp(input logic r, input logic w,
      input logic d, input logic a, input logic [4:0] ev);
      return {16'h0000, r, 2'b00, w, d, a, 5'h00, ev};
   endfunction
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      if (!w) begin
         check({31'h0, bus_rvalid}, 32'h1);
         rd_val = bus_rdata;
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd_val, exp);
   endtask
   task automatic evt(input logic [7:0] e);
      @(posedge sys_clk);
      engine_evt <= e;
      @(posedge sys_clk);
      engine_evt <= '0;
   endtask
   initial begin
      void'($urandom(32'hb615));
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rchk(12'h180, 32'h0);
      rchk(12'h0F0, 32'h0);
      ptr = $urandom;
      ptr[3:0] = ptr[3:0] | 4'h1;
      bus(1'b1, 12'h18C, ptr);
      rchk(12'h18C, ptr);
      check({fetch_block_base, fetch_block_count}, ptr);
      bus(1'b1, 12'h180, 32'hFFFF_FFFF);
      repeat (2) @(posedge sys_clk);
      rchk(12'h180, 32'h0000_8400);
      bus(1'b1, 12'h184, 32'h0000_7FFF);
      rchk(12'h184, 32'h0000_8400);
      check(fetches, 32'h1);
      for (int i = 0; i < 6; i++) begin
         code = 5'($urandom);
         evt({3'b001, code});
         rchk(12'h180, 32'h0000_8400 | {27'h0, code});
      end
      bus(1'b1, 12'h180, 32'h0000_1000);
      rchk(12'h180, ctrl_exp(1'b1, 1'b1, 1'b0, 1'b1, code));
      evt(8'h80);
      rchk(12'h180, 32'h0000_8400 | {27'h0, code});
      evt(8'h40);
      bus(1'b1, 12'h184, 32'h0000_0800);
      rchk(12'h180, ctrl_exp(1'b1, 1'b0, 1'b1, 1'b0, code));
      bus(1'b1, 12'h184, 32'hFFFF_FFFF);
      rchk(12'h184, {27'h0, code});
      n = fetches;
      bus(1'b1, 12'h18C, ptr & 32'hFFFF_FFF0);
      bus(1'b1, 12'h180, 32'h0000_8000);
      repeat (3) @(posedge sys_clk);
      rchk(12'h180, 32'h0000_8000 | {27'h0, code});
      check(fetches, n);
      @(posedge sys_clk);
      soft_reset <= 1'b1;
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      rchk(12'h180, {27'h0, code});
      end_of_test();
   end
endmodule
`default_nettype wire
